// file: rtl/tdw_top.sv
/*
 * transfer descriptor status writeback and retirement.
 * holds the descriptor registers, updates them after each non-NAK
 * transaction, retires to the done queue and runs the done queue
 * writeback.  assumes the engine's outcome and frame_end are
 * synchronous to core_clk; descriptor fetch and memory writes are
 * done by logic outside that loads and reads these registers.
 */
// What this block does
// - toggle control upper bit set means toggle from endpoint, else bit 0
// - on NoError, DataUnderrun or DataOverrun set upper bit and write the inverted selected toggle to lower; else leave field
// - pointer updates only on NoError, DataUnderrun or DataOverrun
// - non-final packet adds bytes; page crossing takes buffer end page
// - final packet with NoError writes zero to the pointer
// - error count up on transmission errors, zero on NoError, else kept
// - transmission error at count two retires with that code
// - store engine code; DataUnderrun with rounding stored as NoError
// - NAK leaves the general descriptor untouched, no writeback
// - isochronous status word: code plus zero for OUT or IN byte count
// - isochronous code is NoError, or DataOverrun when late
// - codes 0000 to 0111: NoError through unexpected PID
// - overrun, underrun and buffer codes; software presets 111x
// - retire when done, count three, late, or fatal code
// - dequeue copies the next link into the endpoint head pointer
// - enqueue writes done head to next link, then done head gets address
// - retire loads a smaller delay; error clears counter; 111b leaves it
// - retire updates endpoint pointer, toggle carry, halt on non-isochronous failure only
// - counter is 3 bits, set to 111b on resets and entering operation
// - decrement at frame boundary when neither 111b nor 0
// - counter 0 and flag clear: write done head, set flag, clear, reload
// - status word bit fields for code, count, toggle, delay, direction
`timescale 1ns/1ps
`default_nettype none

module tdw_top
   import tdw_pkg::*;
(
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        rstn,
   // register port
   input  wire logic [3:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   // serial engine outcome
   input  wire logic        xact_done,
   input  wire logic [3:0]  xact_cc,
   input  wire logic [11:0] xact_bytes,
   input  wire logic        xact_in,
   input  wire logic        xact_last,
   input  wire logic        xact_cross,
   input  wire logic        xact_late,
   input  wire logic        xact_odd,
   // frame timing
   input  wire logic        frame_end,
   // outputs
   output logic             td_writeback,
   output logic             td_retired,
   output logic             hcca_write,
   output logic      [31:0] hcca_head,
   output logic             done_irq
);

   // ----------------------------------------------------------------
   // descriptor and queue state
   // ----------------------------------------------------------------
   logic [31:0] dw0_reg;
   logic [31:0] dw1_reg;
   logic [31:0] dw2_reg;
   logic [31:0] dw3_reg;
   logic [31:0] ofs0_reg;
   logic [31:0] done_reg;
   logic [31:0] ed_head_reg;
   logic [31:0] td_addr_reg;
   logic [2:0]  ctrl_reg;
   logic        wdh_reg;
   logic        oper_d_reg;
   logic [2:0]  cnt;
   logic        wb_now;
   logic        wdh_clr;
   logic        retire_now;

   tdw_ev_if ev ();

   assign ev.dw0      = dw0_reg;
   assign ev.dw1      = dw1_reg;
   assign ev.dw3      = dw3_reg;
   assign ev.ofs0     = ofs0_reg;
   assign ev.iso      = ctrl_reg[CT_ISO];
   assign ev.late     = xact_late;
   assign ev.last_pkt = xact_last;
   assign ev.odd_r    = xact_odd;
   assign ev.crossed  = xact_cross;
   assign ev.sie_cc   = xact_cc;
   assign ev.bytes    = xact_bytes;
   assign ev.is_in    = xact_in;
   assign ev.ed_tog   = ed_head_reg[ED_C];

   tdw_status_calc u_calc (
      .ev (ev.calc)
   );

   // ----------------------------------------------------------------
   // register port decode
   // ----------------------------------------------------------------
   function automatic logic wr_hit(input logic [3:0] a, input logic [3:0] o,
                                   input logic w);
      return w && (a == o);
   endfunction

   assign retire_now = xact_done && !ev.nak && ev.retire;
   // writeback only while operational; flag blocks a second one
   assign wb_now  = ctrl_reg[CT_OPER] && frame_end && cnt == DQ_ZERO &&
                    !wdh_reg;
   assign wdh_clr = wr_hit(reg_addr, A_STAT, reg_wr) && reg_wdata[ST_WDH];

   // status word; engine writeback wins over software load
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn)
         dw0_reg <= ZERO32;
      else if (xact_done && !ev.nak)
         dw0_reg <= ev.dw0_new;
      else if (wr_hit(reg_addr, A_DW0, reg_wr))
         dw0_reg <= reg_wdata;
   end

   // current buffer pointer
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn)
         dw1_reg <= ZERO32;
      else if (xact_done && !ev.nak && !ctrl_reg[CT_ISO])
         dw1_reg <= ev.dw1_new;
      else if (wr_hit(reg_addr, A_DW1, reg_wr))
         dw1_reg <= reg_wdata;
   end

   // next link; takes the done head on retirement
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn)
         dw2_reg <= ZERO32;
      else if (retire_now)
         dw2_reg <= done_reg;
      else if (wr_hit(reg_addr, A_DW2, reg_wr))
         dw2_reg <= reg_wdata;
   end

   // buffer end, loaded by software only
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn)
         dw3_reg <= ZERO32;
      else if (wr_hit(reg_addr, A_DW3, reg_wr))
         dw3_reg <= reg_wdata;
   end

   // isochronous offset pair
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn)
         ofs0_reg <= ZERO32;
      else if (xact_done && ctrl_reg[CT_ISO])
         ofs0_reg <= ev.ofs0_new;
      else if (wr_hit(reg_addr, A_OFS0, reg_wr))
         ofs0_reg <= reg_wdata;
   end

   // address of the descriptor being serviced
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn)
         td_addr_reg <= ZERO32;
      else if (wr_hit(reg_addr, A_TDADDR, reg_wr))
         td_addr_reg <= reg_wdata;
   end

   // done head; a same-cycle retire follows the writeback
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn)
         done_reg <= ZERO32;
      else if (ctrl_reg[CT_SRST])
         done_reg <= ZERO32;
      else if (retire_now)
         done_reg <= td_addr_reg;
      else if (wb_now)
         done_reg <= ZERO32;
   end

   // endpoint head pointer with halt and toggle carry
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn)
         ed_head_reg <= ZERO32;
      else if (retire_now) begin
         ed_head_reg[31:4]  <= dw2_reg[31:4];
         ed_head_reg[ED_C]  <= ev.dw0_new[TG_LO];
         ed_head_reg[ED_H]  <= ed_head_reg[ED_H] |
                               (ev.fail && !ctrl_reg[CT_ISO]);
      end else if (wr_hit(reg_addr, A_ED_HEAD, reg_wr))
         ed_head_reg <= reg_wdata;
   end

   // control; soft reset bit self clears
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn)
         ctrl_reg <= 3'h0;
      else if (wr_hit(reg_addr, A_CTRL, reg_wr))
         ctrl_reg <= reg_wdata[2:0];
      else
         ctrl_reg[CT_SRST] <= 1'b0;
   end

   // operational edge detect for the counter reload
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn)
         oper_d_reg <= 1'b0;
      else
         oper_d_reg <= ctrl_reg[CT_OPER];
   end

   // writeback flag; setting wins over a clear in the same cycle
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn)
         wdh_reg <= 1'b0;
      else if (wb_now)
         wdh_reg <= 1'b1;
      else if (wdh_clr || ctrl_reg[CT_SRST])
         wdh_reg <= 1'b0;
   end

   tdw_dq_counter u_cnt (
      .core_clk   (core_clk),
      .rstn       (rstn),
      .soft_rst   (ctrl_reg[CT_SRST]),
      .oper       (ctrl_reg[CT_OPER]),
      .oper_enter (ctrl_reg[CT_OPER] && !oper_d_reg),
      .frame_end  (frame_end),
      .wb_done    (wb_now),
      .retire     (retire_now),
      .fail       (ev.fail),
      .delay      (dw0_reg[DI_HI:DI_LO]),
      .cnt_reg    (cnt)
   );

   // ----------------------------------------------------------------
   // event outputs, registered
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         td_writeback <= 1'b0;
         td_retired   <= 1'b0;
         hcca_write   <= 1'b0;
         hcca_head    <= ZERO32;
         done_irq     <= 1'b0;
      end else begin
         td_writeback <= xact_done && !ev.nak;
         td_retired   <= retire_now;
         hcca_write   <= wb_now;
         done_irq     <= wb_now;
         if (wb_now)
            hcca_head <= done_reg;
      end
   end

   // ----------------------------------------------------------------
   // register read, one cycle after the strobe
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn)
         reg_rdata <= ZERO32;
      else if (reg_rd) begin
         case (reg_addr)
            A_DW0:     reg_rdata <= dw0_reg;
            A_DW1:     reg_rdata <= dw1_reg;
            A_DW2:     reg_rdata <= dw2_reg;
            A_DW3:     reg_rdata <= dw3_reg;
            A_OFS0:    reg_rdata <= ofs0_reg;
            A_DONE:    reg_rdata <= done_reg;
            A_ED_HEAD: reg_rdata <= ed_head_reg;
            A_CTRL:    reg_rdata <= {29'h0, ctrl_reg};
            A_STAT:    reg_rdata <= {25'h0, cnt, 3'h0, wdh_reg};
            A_TDADDR:  reg_rdata <= td_addr_reg;
            A_HCCA:    reg_rdata <= hcca_head;
            default:   reg_rdata <= ZERO32;   // unmapped reads zero
         endcase
      end else
         reg_rdata <= ZERO32;
   end

endmodule

`default_nettype wire

// file: rtl/tdw_pkg.sv
/*
 * package for the descriptor status writeback and retire block:
 * completion codes, descriptor field positions, register offsets,
 * reset values.
 * assumes nothing of its surroundings.
 */
package tdw_pkg;

   // ----------------------------------------------------------------
   // completion codes
   // ----------------------------------------------------------------
   localparam logic [3:0] CC_NOERR    = 4'h0;
   localparam logic [3:0] CC_CRC      = 4'h1;
   localparam logic [3:0] CC_BITSTUFF = 4'h2;
   localparam logic [3:0] CC_TOGGLE   = 4'h3;
   localparam logic [3:0] CC_STALL    = 4'h4;
   localparam logic [3:0] CC_NORESP   = 4'h5;
   localparam logic [3:0] CC_PIDCHK   = 4'h6;
   localparam logic [3:0] CC_UNEXPID  = 4'h7;
   localparam logic [3:0] CC_DOVR     = 4'h8;
   localparam logic [3:0] CC_DUNR     = 4'h9;
   localparam logic [3:0] CC_BOVR     = 4'hC;
   localparam logic [3:0] CC_BUNR     = 4'hD;
   localparam logic [3:0] CC_NOTACC   = 4'hE;

   // ----------------------------------------------------------------
   // status word fields
   // ----------------------------------------------------------------
   localparam int CC_HI  = 31;
   localparam int CC_LO  = 28;
   localparam int EC_HI  = 27;
   localparam int EC_LO  = 26;
   localparam int TG_HI  = 25;
   localparam int TG_LO  = 24;
   localparam int DI_HI  = 23;
   localparam int DI_LO  = 21;
   localparam int DIR_HI = 20;
   localparam int DIR_LO = 19;
   localparam int PG_LO  = 12;      // page base starts here
   localparam int PSW_SZ = 12;      // size bits in a packet status half

   localparam logic [1:0] EC_LIMIT = 2'h2;
   localparam logic [2:0] DQ_IDLE  = 3'h7;
   localparam logic [2:0] DQ_ZERO  = 3'h0;

   // ----------------------------------------------------------------
   // register offsets (word addresses)
   // ----------------------------------------------------------------
   localparam logic [3:0] A_DW0     = 4'h0;
   localparam logic [3:0] A_DW1     = 4'h1;
   localparam logic [3:0] A_DW2     = 4'h2;
   localparam logic [3:0] A_DW3     = 4'h3;
   localparam logic [3:0] A_OFS0    = 4'h4;
   localparam logic [3:0] A_DONE    = 4'h5;
   localparam logic [3:0] A_ED_HEAD = 4'h6;
   localparam logic [3:0] A_CTRL    = 4'h7;
   localparam logic [3:0] A_STAT    = 4'h8;
   localparam logic [3:0] A_TDADDR  = 4'h9;
   localparam logic [3:0] A_HCCA    = 4'hA;

   // ctrl bits: 0 operational, 1 isochronous, 2 soft reset
   localparam int CT_OPER = 0;
   localparam int CT_ISO  = 1;
   localparam int CT_SRST = 2;
   // stat bits: 0 writeback done head (write 1 to clear)
   localparam int ST_WDH  = 0;

   // ed head dword: bit0 halt, bit1 toggle carry
   localparam int ED_H = 0;
   localparam int ED_C = 1;

   localparam logic [31:0] ZERO32 = 32'h0000_0000;

endpackage

// file: rtl/tdw_ev_if.sv
/*
 * interface carrying one transaction outcome from the top to the
 * status computing module, and the new field values back.
 * assumes both ends run on core_clk.
 */
`timescale 1ns/1ps
`default_nettype none

interface tdw_ev_if;
   logic [31:0] dw0;
   logic [31:0] dw1;
   logic [31:0] dw3;
   logic [31:0] ofs0;
   logic        iso;
   logic        late;
   logic        last_pkt;
   logic        odd_r;
   logic        crossed;
   logic [3:0]  sie_cc;
   logic [11:0] bytes;
   logic        is_in;
   logic        ed_tog;     // toggle carry held in the endpoint head
   logic [31:0] dw0_new;
   logic [31:0] dw1_new;
   logic [31:0] ofs0_new;
   logic        retire;
   logic        fail;
   logic        nak;

   modport top  (output dw0, dw1, dw3, ofs0, iso, late, last_pkt, odd_r,
                 crossed, sie_cc, bytes, is_in, ed_tog,
                 input dw0_new, dw1_new, ofs0_new, retire, fail, nak);
   modport calc (input dw0, dw1, dw3, ofs0, iso, late, last_pkt, odd_r,
                 crossed, sie_cc, bytes, is_in, ed_tog,
                 output dw0_new, dw1_new, ofs0_new, retire, fail, nak);
endinterface

`default_nettype wire

// file: rtl/tdw_status_calc.sv
/*
 * combinational writeback values for one transaction outcome.
 * assumes inputs are stable in the cycle the top samples them.
 */
`timescale 1ns/1ps
`default_nettype none

module tdw_status_calc
   import tdw_pkg::*;
(
   // outcome in, new values out
   tdw_ev_if.calc ev
);

   // reserved code 1010 is used by the engine to signal a nak
   localparam logic [3:0] CC_NAK_MARK = 4'hA;

   // transmission errors count toward retirement
   function automatic logic is_xerr(input logic [3:0] c);
      return (c == CC_CRC) || (c == CC_BITSTUFF) || (c == CC_TOGGLE) ||
             (c == CC_NORESP) || (c == CC_PIDCHK);
   endfunction

   function automatic logic is_fatal(input logic [3:0] c);
      return (c == CC_STALL) || (c == CC_DOVR) || (c == CC_DUNR) ||
             (c == CC_UNEXPID);
   endfunction

   logic [3:0]  cc;
   logic [1:0]  ec;
   logic [1:0]  tg;
   logic [31:0] sum;
   logic [15:0] psw;
   logic        round;

   // general and isochronous status computation
   always_comb begin
      round       = ev.dw0[PG_LO+6];   // buffer rounding flag, bit 18
      cc          = ev.sie_cc;
      ec          = ev.dw0[EC_HI:EC_LO];
      tg          = ev.dw0[TG_HI:TG_LO];
      sum         = ev.dw1 + {20'h00000, ev.bytes};
      psw         = 16'h0000;
      ev.nak      = 1'b0;
      ev.dw0_new  = ev.dw0;
      ev.dw1_new  = ev.dw1;
      ev.ofs0_new = ev.ofs0;
      ev.retire   = 1'b0;
      ev.fail     = 1'b0;
      if (ev.iso) begin
         // late descriptor records overrun, else no error
         cc = ev.late ? CC_DOVR : CC_NOERR;
         psw = {cc, (ev.is_in ? ev.bytes : 12'h000)};
         if (!ev.late) begin
            if (ev.odd_r)
               ev.ofs0_new[31:16] = psw;
            else
               ev.ofs0_new[15:0] = psw;
         end
         ev.dw0_new[CC_HI:CC_LO] = cc;
         ev.retire = ev.late || ev.last_pkt;
         ev.fail   = ev.late;
      end else if (ev.sie_cc == CC_NAK_MARK) begin
         ev.nak = 1'b1;
      end else begin
         if (cc == CC_DUNR && round)
            cc = CC_NOERR;
         if (cc == CC_NOERR)
            ec = 2'h0;
         else if (is_xerr(cc))
            ec = ec + 2'h1;
         if (cc == CC_NOERR || cc == CC_DUNR || cc == CC_DOVR)
            tg = {1'b1, ~(tg[1] ? ev.ed_tog : tg[0])};
         // pointer only advances when the packet can't be retried
         if (cc == CC_NOERR || cc == CC_DUNR || cc == CC_DOVR) begin
            if (ev.last_pkt && cc == CC_NOERR)
               ev.dw1_new = ZERO32;
            else if (ev.crossed)
               ev.dw1_new = {ev.dw3[31:PG_LO], sum[PG_LO-1:0]};
            else
               ev.dw1_new = sum;
         end
         ev.dw0_new[CC_HI:CC_LO] = cc;
         ev.dw0_new[EC_HI:EC_LO] = ec;
         ev.dw0_new[TG_HI:TG_LO] = tg;
         ev.fail   = (is_xerr(cc) && ev.dw0[EC_HI:EC_LO] == EC_LIMIT) ||
                     is_fatal(cc);
         ev.retire = ev.fail || (ev.last_pkt && cc == CC_NOERR);
      end
   end

endmodule

`default_nettype wire

// file: rtl/tdw_dq_counter.sv
/*
 * done queue interrupt counter.
 * assumes frame_end is a one-cycle pulse on the last bit time.
 */
`timescale 1ns/1ps
`default_nettype none

module tdw_dq_counter
   import tdw_pkg::*;
(
   // clock and reset
   input  wire logic       core_clk,
   input  wire logic       rstn,
   // control
   input  wire logic       soft_rst,
   input  wire logic       oper,
   input  wire logic       oper_enter,
   input  wire logic       frame_end,
   input  wire logic       wb_done,
   input  wire logic       retire,
   input  wire logic       fail,
   input  wire logic [2:0] delay,
   // state
   output logic      [2:0] cnt_reg
);

   logic [2:0] cnt_next;

   // next counter value; writeback reload beats decrement
   always_comb begin
      cnt_next = cnt_reg;
      if (oper && frame_end && cnt_reg != DQ_IDLE && cnt_reg != DQ_ZERO)
         cnt_next = cnt_reg - 3'h1;
      if (retire) begin
         if (fail)
            cnt_next = DQ_ZERO;
         else if (delay != DQ_IDLE && delay < cnt_next)
            cnt_next = delay;
      end
      if (wb_done)
         cnt_next = DQ_IDLE;
      if (soft_rst || oper_enter)
         cnt_next = DQ_IDLE;
   end

   // counter register
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn)
         cnt_reg <= DQ_IDLE;
      else
         cnt_reg <= cnt_next;
   end

endmodule

`default_nettype wire

// file: tb/tdw_chk.sv
/* port checker for tdw_top.
   assumes one clock domain, rstn async active low. */
`timescale 1ns/1ps
`default_nettype none
module tdw_chk
   import tdw_pkg::*;
(
   // clock and reset
   input wire logic        core_clk,
   input wire logic        rstn,
   // engine and frame
   input wire logic        xact_done,
   input wire logic [3:0]  xact_cc,
   input wire logic        xact_last,
   input wire logic        frame_end,
   // block outputs
   input wire logic        td_writeback,
   input wire logic        td_retired,
   input wire logic        hcca_write,
   input wire logic [31:0] hcca_head,
   input wire logic        done_irq
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);
   // ----------------------------------------------------------------
   // outcome handling
   // ----------------------------------------------------------------
   AST_WB_AFTER: assert property (xact_done && xact_cc != 4'hA |=> td_writeback)
      else $error("no writeback after outcome");
   AST_WB_CAUSE: assert property (td_writeback |-> $past(xact_done) && $past(xact_cc) != 4'hA)
      else $error("writeback without outcome");
   AST_RET_FATAL: assert property (xact_done && (xact_cc == CC_STALL || xact_cc == CC_UNEXPID) |=> td_retired)
      else $error("fatal code not retired");
   AST_RET_LAST: assert property (xact_done && xact_last && xact_cc == CC_NOERR |=> td_retired)
      else $error("final packet not retired");
   AST_RET_CAUSE: assert property (td_retired |-> $past(xact_done))
      else $error("retire without outcome");
   // ----------------------------------------------------------------
   // done head writeout
   // ----------------------------------------------------------------
   AST_IRQ_PAIR: assert property (done_irq == hcca_write)
      else $error("interrupt apart from writeout");
   AST_HCCA_FRAME: assert property (hcca_write |-> $past(frame_end))
      else $error("writeout off the frame end");
   AST_ONE_WB: assert property (hcca_write |=> !hcca_write [*8])
      else $error("writeout repeated");
   AST_HEAD_HOLD: assert property (!$stable(hcca_head) |-> hcca_write)
      else $error("head copy moved");
   CV_RET: cover property (td_retired);
   CV_WB: cover property (hcca_write);
   CV_NAK: cover property (xact_done && xact_cc == 4'hA);
endmodule
`default_nettype wire

// file: tb/tdw_sie_model.sv
/* serial engine model: outcome pulses and frame ends.
   assumes the caller waits in a task; fields scrambled once released. */
`timescale 1ns/1ps
`default_nettype none
module tdw_sie_model
   import tdw_pkg::*;
(
   // clock
   input  wire logic   core_clk,
   // outcome, flags are in,last,cross,late,odd
   output logic        xact_done,
   output logic [3:0]  xact_cc,
   output logic [11:0] xact_bytes,
   output logic [4:0]  xact_f,
   // frame timing
   output logic        frame_end
);
   // ----------------------------------------------------------------
   // idle levels
   // ----------------------------------------------------------------
   initial begin
      xact_done = 1'b0;
      xact_cc = CC_NOTACC;
      xact_bytes = 12'h000;
      xact_f = 5'h00;
      frame_end = 1'b0;
   end
   // one outcome after gap idle cycles; stale fields are inverted so
   // nothing can lean on them
   task automatic xfer(input logic [3:0] cc, input logic [11:0] n,
                       input logic [4:0] f, input int gap);
      repeat (gap) @(posedge core_clk);
      @(posedge core_clk);
      xact_done <= 1'b1;
      xact_cc <= cc;
      xact_bytes <= n;
      xact_f <= f;
      @(posedge core_clk);
      xact_done <= 1'b0;
      xact_cc <= ~cc;
      xact_bytes <= ~n;
      xact_f <= ~f;
      #1;
   endtask
   // last bit time of a frame
   task automatic frame();
      @(posedge core_clk);
      frame_end <= 1'b1;
      @(posedge core_clk);
      frame_end <= 1'b0;
      #1;
   endtask
endmodule
`default_nettype wire

// file: tb/tb_td_status_writeback_retire.sv
/* testbench for tdw_top through its register port and engine model.
   assumes the hand-over register map and tdw_pkg constants. */
`timescale 1ns/1ps
`default_nettype none
module tb_td_status_writeback_retire
   import tdw_pkg::*;
   ;
   logic        core_clk, rstn, reg_wr, reg_rd, xact_done, frame_end;
   logic        td_writeback, td_retired, hcca_write, done_irq;
   logic [3:0]  reg_addr, xact_cc;
   logic [31:0] reg_wdata, reg_rdata, hcca_head;
   logic [11:0] xact_bytes;
   logic [4:0]  f;
   int          bad_count = 0;
   int          n_compared = 0;
   logic [3:0]  ecs [5] = '{CC_CRC, CC_BITSTUFF, CC_TOGGLE, CC_NORESP, CC_PIDCHK};
   tdw_top uut (.core_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .xact_done, .xact_cc, .xact_bytes, .xact_in(f[4]), .xact_last(f[3]),
      .xact_cross(f[2]), .xact_late(f[1]), .xact_odd(f[0]), .frame_end,
      .td_writeback, .td_retired, .hcca_write, .hcca_head, .done_irq);
   tdw_sie_model sie (.core_clk, .xact_done, .xact_cc, .xact_bytes, .xact_f(f), .frame_end);
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string w);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", w, exp, seen);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   // masked read, data looked at in the one cycle it stands
   task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e,
                     input string w);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      check(reg_rdata & m, e, w);
   endtask
   task automatic complete_run();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // hang guard
   initial begin
      #100us;
      bad_count++;
      complete_run();
   end
   initial begin
      rstn = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = ZERO32;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      repeat (3) @(posedge core_clk);
      rstn <= 1'b1;
      rd(A_STAT, 32'hFF, 32'h70, "cnt");
      rd(4'hF, '1, ZERO32, "unmapped");
      wr(A_CTRL, 32'h1);
      wr(A_TDADDR, 32'h1230);
      wr(A_DW2, 32'h4560);
      wr(A_DW1, 32'h1FF0);
      wr(A_DW3, 32'h5FFF);
      // success crossing a page
      wr(A_DW0, 32'hE400_0000);
      sie.xfer(CC_NOERR, 12'h020, 5'b00100, 0);
      check(32'(td_writeback), 32'h1, "wb");
      rd(A_DW0, '1, 32'h0300_0000, "dw0");
      rd(A_DW1, '1, 32'h5010, "cbp");
      // every transmission error counts once, slow answers too
      foreach (ecs[i]) begin
         wr(A_DW0, 32'h0300_0000);
         sie.xfer(ecs[i], 12'h010, 5'b0, i);
         rd(A_DW0, '1, {ecs[i], 28'h700_0000}, "ec");
      end
      rd(A_DW1, '1, 32'h5010, "cbp kept");
      sie.xfer(4'hA, 12'h010, 5'b0, 0);
      check(32'(td_writeback), ZERO32, "nak wb");
      rd(A_DW0, '1, 32'h6700_0000, "nak dw0");
      // third error retires, halts and clears the counter
      wr(A_DW0, 32'h0B60_0000);
      sie.xfer(CC_CRC, 12'h000, 5'b0, 0);
      check(32'(td_retired), 32'h1, "ret");
      rd(A_DW0, 32'hF000_0000, 32'h1000_0000, "ret cc");
      rd(A_STAT, 32'h70, ZERO32, "cnt clr");
      rd(A_ED_HEAD, '1, 32'h4563, "ed");
      rd(A_DONE, '1, 32'h1230, "head");
      rd(A_DW2, '1, ZERO32, "link");
      sie.frame();
      check(32'(hcca_write & done_irq), 32'h1, "wout");
      check(hcca_head, 32'h1230, "hcca");
      rd(A_STAT, 32'h71, 32'h71, "wdh");
      rd(A_DONE, '1, ZERO32, "head clr");
      wr(A_STAT, 32'h1);
      $display("test done: general");
      // final packet with delay 3, then the frame countdown
      wr(A_DW0, 32'h0060_0000);
      sie.xfer(CC_NOERR, 12'h010, 5'b01000, 0);
      rd(A_DW1, '1, ZERO32, "final cbp");
      rd(A_STAT, 32'h71, 32'h30, "delay");
      for (int k = 2; k >= 0; k--) begin
         sie.frame();
         rd(A_STAT, 32'h70, {25'h0, k[2:0], 4'h0}, "dec");
      end
      sie.frame();
      check(32'(hcca_write), 32'h1, "wout2");
      wr(A_DW0, 32'h00E0_0000);
      sie.xfer(CC_NOERR, 12'h000, 5'b01000, 0);
      sie.frame();
      rd(A_STAT, 32'h70, 32'h70, "no delay");
      wr(A_ED_HEAD, ZERO32);
      wr(A_DW0, 32'h0304_0000);
      wr(A_DW1, 32'h2000);
      sie.xfer(CC_DUNR, 12'h008, 5'b0, 0);
      check(32'(td_retired), ZERO32, "round ret");
      rd(A_DW0, '1, 32'h0304_0000, "round cc");
      rd(A_DW1, '1, 32'h2008, "round cbp");
      $display("test done: counter");
      // isochronous status words and the late case
      wr(A_CTRL, 32'h3);
      wr(A_OFS0, 32'hE000_E000);
      sie.xfer(CC_NOERR, 12'h040, 5'b10000, 0);
      rd(A_OFS0, '1, 32'hE000_0040, "in psw");
      sie.xfer(CC_NOERR, 12'h040, 5'b00001, 0);
      rd(A_OFS0, '1, 32'h0000_0040, "out psw");
      sie.xfer(CC_NOERR, 12'h000, 5'b00010, 0);
      check(32'(td_retired), 32'h1, "late ret");
      rd(A_DW0, 32'hF000_0000, 32'h8000_0000, "late cc");
      wr(A_CTRL, 32'h5);
      rd(A_STAT, 32'h71, 32'h70, "srst");
      $display("test done: iso");
      complete_run();
   end
endmodule
bind tdw_top tdw_chk chk (.core_clk, .rstn, .xact_done, .xact_cc, .xact_last, .frame_end,
   .td_writeback, .td_retired, .hcca_write, .hcca_head, .done_irq);
`default_nettype wire
